// ==== ovl_map.sv ====
// Purpose: Maps core memory accesses to on-chip RAM or external overlays.
// Assumes: Inputs are synchronous to pclk; external memory answers on time.
// Notes: Registers reached over APB; ctrl at 0x000, status at 0x004.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
`timescale 1ns/100ps
`include "ovl_defs.svh"
module ovl_map
    import ovl_pkg::*;
#(
    parameter int PM_WORDS = `PM_RAM_WORDS,
    parameter int DM_WORDS = `DM_RAM_WORDS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire core_req_t         core_req,
    output logic                   core_done,
    output logic [23:0]            core_rdata,
    output logic                   fetch_fault,
    output ext_bus_t               ext_bus,
    input  wire logic [23:0]       ext_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks.
    if (PM_WORDS < 1 || PM_WORDS > `PM_RAM_WORDS) begin : g_pm_chk
        $error("PM_WORDS out of range");
    end
    if (DM_WORDS < 1 || DM_WORDS > `DM_RAM_WORDS) begin : g_dm_chk
        $error("DM_WORDS out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and APB slave.
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    wire         apb_setup   = psel && !penable;
    wire         apb_access  = psel && penable && pready_ff;
    wire         hit_ctrl    = (paddr == `REG_CTRL);
    wire         hit_stat    = (paddr == `REG_STAT);
    wire         hit_any     = hit_ctrl || hit_stat;
    wire [3:0]   pm_ovl      = ctrl_ff[`CTRL_PM_LSB +: 4];
    wire [3:0]   dm_ovl      = ctrl_ff[`CTRL_DM_LSB +: 4];
    wire [2:0]   wait_cnt    = ctrl_ff[`CTRL_WAIT_LSB +: 3];
    wire         wait_mode   = ctrl_ff[`CTRL_WMODE_BIT];
    wire         host_mode   = ctrl_ff[`CTRL_HOST_BIT];
    assign nxt_ctrl = {19'h0, pwdata[12:0]};

    acc_state_t  state_ff;
    logic [3:0]  wait_ff;
    wire [31:0]  stat_word = {28'h0, wait_ff};
    wire [31:0]  rd_mux    = hit_ctrl ? ctrl_ff : (hit_stat ? stat_word : 32'h0000_0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= `CTRL_RESET;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (clk_en) begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup && !hit_any;
            prdata_ff  <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
            if (apb_access && pwrite && hit_ctrl) begin
                ctrl_ff <= nxt_ctrl;
            end
        end
    end
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    function automatic logic ovl_ext(input logic [3:0] sel);
        return (sel == `OVL_EXT1) || (sel == `OVL_EXT2);
    endfunction

    function automatic logic [13:0] ext_addr(input logic [3:0] sel, input logic [15:0] a, input logic host);
        if (host) begin
            return {13'h0, a[0]};
        end
        return {(sel == `OVL_EXT2), a[12:0]};
    endfunction

    wire pm_in_win = core_req.addr[15:13] == 3'b001;
    wire dm_in_win = core_req.addr[15:13] == 3'b000;
    wire is_ext    = core_req.pm_space ? (pm_in_win && ovl_ext(pm_ovl))
                                       : (dm_in_win && ovl_ext(dm_ovl));
    wire bad_fetch = core_req.req && is_ext && core_req.pm_space && core_req.fetch && host_mode;
    wire [3:0] sel_v = core_req.pm_space ? pm_ovl : dm_ovl;
    wire [3:0] wait_load = wait_mode ? {wait_cnt, 1'b1} : {1'b0, wait_cnt};

    ////////////////////////////////////////////////////////////////////////
    // On-chip memories.
    // memory spaces
    logic [23:0] pm_ram [PM_WORDS];
    logic [15:0] dm_ram [DM_WORDS];
    logic [15:0] dm_regs [`DM_REG_COUNT];
    wire  [15:0] a       = core_req.addr;
    wire         dm_reg  = !core_req.pm_space && (a[15:5] == 11'(`DM_REG_BASE >> 5));
    wire [4:0]   reg_idx = a[4:0];
    wire         pm_ok   = 32'(a) < PM_WORDS;
    wire         dm_ok   = 32'(a) < DM_WORDS;
    wire [23:0]  int_rd  = core_req.pm_space ? (pm_ok ? pm_ram[a] : 24'h00_0000)
                          : dm_reg ? {8'h00, dm_regs[reg_idx]}
                          : {8'h00, (dm_ok ? dm_ram[a] : 16'h0000)};
    wire         int_go  = core_req.req && !is_ext;

    always_ff @(posedge pclk) begin
        if (clk_en && int_go && core_req.wr) begin
            if (core_req.pm_space && pm_ok) begin
                pm_ram[a] <= core_req.wdata;
            end else if (dm_reg) begin
                dm_regs[reg_idx] <= core_req.wdata[15:0];
            end else if (!core_req.pm_space && dm_ok) begin
                dm_ram[a] <= core_req.wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer.
    logic        done_ff;
    logic [23:0] rdata_ff;
    logic        fault_ff;
    ext_bus_t    bus_ff;
    logic        ext_pm_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= ST_IDLE;
            wait_ff   <= 4'h0;
            done_ff   <= 1'b0;
            rdata_ff  <= 24'h00_0000;
            fault_ff  <= 1'b0;
            ext_pm_ff <= 1'b0;
            bus_ff    <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 14'h0000, wdata: 24'h00_0000};
        end else if (clk_en) begin
            done_ff  <= 1'b0;
            fault_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE, ST_INT: begin
                    state_ff <= ST_IDLE;
                    if (bad_fetch) begin
                        fault_ff <= 1'b1;
                        done_ff  <= 1'b1;
                    end else if (int_go) begin
                        done_ff  <= 1'b1;
                        rdata_ff <= int_rd;
                        state_ff <= ST_INT;
                    end else if (core_req.req) begin
                        state_ff  <= ST_EXT;
                        wait_ff   <= wait_load;
                        ext_pm_ff <= core_req.pm_space;
                        bus_ff    <= '{sel_n: 1'b0, rd_n: core_req.wr, wr_n: !core_req.wr,
                                      addr: ext_addr(sel_v, a, host_mode), wdata: core_req.wdata};
                    end
                end
                ST_EXT: begin
                    if (wait_ff != 4'h0) begin
                        wait_ff <= wait_ff - 4'h1;
                    end else begin
                        done_ff  <= 1'b1;
                        rdata_ff <= ext_pm_ff ? ext_rdata : {8'h00, ext_rdata[15:0]};
                        bus_ff   <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: bus_ff.addr, wdata: bus_ff.wdata};
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    assign core_done   = done_ff;
    assign core_rdata  = rdata_ff;
    assign fetch_fault = fault_ff;
    assign ext_bus     = bus_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    property p_int_one_cycle;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state_ff != ST_EXT && int_go && !bad_fetch) |=> core_done;
    endproperty
    a_int_one_cycle: assert property (p_int_one_cycle) else $error("internal access not one cycle");

    property p_ext_wait;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state_ff != ST_EXT && core_req.req && is_ext && !bad_fetch && wait_load == 4'h5)
            ##1 clk_en [*6] |=> core_done;
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("external wait count wrong");

    property p_pm_a13;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state_ff != ST_EXT && core_req.req && core_req.pm_space && pm_in_win
            && pm_ovl == `OVL_EXT2 && !host_mode && !core_req.fetch) |=> ext_bus.addr[13] && !ext_bus.sel_n;
    endproperty
    a_pm_a13: assert property (p_pm_a13) else $error("program overlay A13 wrong");

    property p_dm_a13;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state_ff != ST_EXT && core_req.req && !core_req.pm_space && dm_in_win
            && dm_ovl == `OVL_EXT1 && !host_mode) |=> !ext_bus.addr[13] && ext_bus.addr[12:0] == $past(core_req.addr[12:0]);
    endproperty
    a_dm_a13: assert property (p_dm_a13) else $error("data overlay address wrong");

    property p_host_a0;
        @(posedge pclk) disable iff (!presetn)
        (host_mode && !ext_bus.sel_n) |-> ext_bus.addr[13:1] == 13'h0000;
    endproperty
    a_host_a0: assert property (p_host_a0) else $error("host mode drives high address");

    property p_host_fetch;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && bad_fetch && state_ff != ST_EXT) |=> fetch_fault && ext_bus.sel_n;
    endproperty
    a_host_fetch: assert property (p_host_fetch) else $error("host fetch not refused");

    property p_outside_int;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state_ff != ST_EXT && core_req.req && core_req.pm_space && !pm_in_win) |=> ext_bus.sel_n;
    endproperty
    a_outside_int: assert property (p_outside_int) else $error("outside window went external");

    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && psel && !penable) |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb not ready");

    property p_int_no_select;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state_ff != ST_EXT && int_go) |=> ext_bus.sel_n;
    endproperty
    a_int_no_select: assert property (p_int_no_select) else $error("internal access drove select");

    c_host_ext: cover property (@(posedge pclk) disable iff (!presetn) host_mode && !ext_bus.sel_n);

    c_int: cover property (@(posedge pclk) disable iff (!presetn) core_done && state_ff == ST_INT);
    c_ext: cover property (@(posedge pclk) disable iff (!presetn) !ext_bus.sel_n ##1 ext_bus.sel_n);
    c_fault: cover property (@(posedge pclk) disable iff (!presetn) fetch_fault);
endmodule // ovl_map
`default_nettype wire

// ==== ovl_defs.svh ====
// Purpose: Constants for the memory overlay address map block.
// Assumes: Included by the design module only; the package does not include it.
// Notes: Offsets, field positions, reset values and sizes.
// Behaviour
// - Program words are 24 bits wide.
// - Up to 48K words program RAM.
// - Full mode: two 8K external program overlays.
// - Program window 0x2000-0x3FFF external, A13 from select.
// - Data window 0x0000-0x1FFF external, A13 from select.
// - Data words are 16 bits wide.
// - Up to 56K words data RAM.
// - Data space reserves 32 control registers.
// - Full mode: two 8K external data overlays.
// - Internal access completes in one cycle.
// - External data access stretched by wait count.
// - Host mode: program overlay uses A0 only.
// - Host mode: data overlay uses A0 only.
// - Host mode: no external program execution.
`ifndef OVL_DEFS_SVH
`define OVL_DEFS_SVH
`define PM_WIN_LO      14'h2000
`define PM_WIN_HI      14'h3fff
`define DM_WIN_LO      14'h0000
`define DM_WIN_HI      14'h1fff
`define OVL_EXT1       4'h1
`define OVL_EXT2       4'h2
`define PM_RAM_WORDS   49152
`define DM_RAM_WORDS   57344
`define DM_REG_COUNT   32
`define DM_REG_BASE    16'h3fe0
`define REG_CTRL       12'h000
`define REG_STAT       12'h004
`define CTRL_PM_LSB    0
`define CTRL_DM_LSB    4
`define CTRL_WAIT_LSB  8
`define CTRL_WMODE_BIT 11
`define CTRL_HOST_BIT  12
`define CTRL_RESET     32'h0000_0000
`endif

// ==== ovl_pkg.sv ====
// Purpose: Types for the memory overlay address map block.
// Assumes: Nothing beyond the header.
// Notes: Request and external bus bundles travel as packed structs.
`default_nettype none
package ovl_pkg;
    typedef struct packed {
        logic        req;
        logic        pm_space;
        logic        wr;
        logic        fetch;
        logic [15:0] addr;
        logic [23:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic        sel_n;
        logic        rd_n;
        logic        wr_n;
        logic [13:0] addr;
        logic [23:0] wdata;
    } ext_bus_t;

    typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_EXT} acc_state_t;
endpackage
`default_nettype wire

// ==== ovl_sram_model.sv ====
// Purpose: Behavioural external overlay SRAM on the external bus.
// Assumes: Select and strobes are active low levels.
// Notes: A released data bus shows the inverse of its last value.
`timescale 1ns/100ps
`default_nettype none
module ovl_sram_model
    import ovl_pkg::*;
(
    input  wire logic     pclk,
    input  wire ext_bus_t ext_bus,
    output logic [23:0]   ext_rdata
);
    logic [23:0] mem [0:16383];
    logic [23:0] last_ff = 24'h00_0000;
    wire         rd_on = !ext_bus.sel_n && !ext_bus.rd_n;

    assign ext_rdata = rd_on ? mem[ext_bus.addr] : ~last_ff;

    always_ff @(posedge pclk) begin
        last_ff <= ext_rdata;
        if (!ext_bus.sel_n && !ext_bus.wr_n) begin
            mem[ext_bus.addr] <= ext_bus.wdata;
        end
    end
endmodule // ovl_sram_model
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the overlay address map.
// Assumes: clk_en tied high; the external SRAM answers at once.
// Notes: Core latencies follow the hand-over timing of the block.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ovl_pkg::*;
();
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    core_req_t   core_req = '0;
    logic        core_done;
    logic [23:0] core_rdata;
    logic        fetch_fault;
    ext_bus_t    ext_bus;
    logic [23:0] ext_rdata;
    int          n_errors = 0;
    int          comparisons = 0;

    ////////////////////////////////////////////////////////////////
    ovl_map dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_req(core_req), .core_done(core_done), .core_rdata(core_rdata),
        .fetch_fault(fetch_fault), .ext_bus(ext_bus), .ext_rdata(ext_rdata));
    ovl_sram_model sram (.pclk(pclk), .ext_bus(ext_bus), .ext_rdata(ext_rdata));

    initial begin
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: apb no ready", $time);
        end
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [3:0] pm, input logic [3:0] dm, input logic [2:0] wc,
                       input logic wm, input logic host);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, 12'h000, {19'h0, host, wm, wc, dm, pm}, rd, e);
    endtask

    task automatic core(input logic pm, input logic wr, input logic fe, input logic [15:0] a,
                        input logic [23:0] wd, input logic ext, input logic [13:0] ea,
                        input int w, input logic flt, input logic [23:0] exp_rd);
        int n;
        int lows;
        n = ext ? 2 + w : 1;
        lows = 0;
        @(posedge pclk);
        core_req <= '{1'b1, pm, wr, fe, a, wd};
        for (int k = 1; k <= n + 1; k++) begin
            @(posedge pclk);
            if (k == n) begin
                core_req.req <= 1'b0;
            end
            @(negedge pclk);
            chk(core_done, k == n, "done");
            if (k == n) chk(fetch_fault, flt, "fault");
            if (ext_bus.sel_n === 1'b0) begin
                lows++;
                chk(ext_bus.addr, ea, "ext addr");
                chk({ext_bus.rd_n, ext_bus.wr_n}, {wr, !wr}, "strobes");
                if (wr) chk(ext_bus.wdata, wd, "ext wdata");
            end
        end
        chk(lows, ext ? w + 1 : 0, "select cycles");
        if (!wr && !flt) chk(core_rdata, exp_rd, "rdata");
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] rd;
        logic        e;
        chk(ext_bus.sel_n, 1'b1, "idle select");
        apb(1'b0, 12'h000, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_0000, "ctrl reset");
        apb(1'b1, 12'h000, 32'h0000_1fff, rd, e);
        apb(1'b1, 12'h008, 32'h0000_0000, rd, e);
        chk(e, 1'b1, "unmapped");
        apb(1'b0, 12'h000, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_1fff, "ctrl rw");
        apb(1'b0, 12'h004, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_0000, "status idle");
        $display("Test regs done");
    endtask

    task automatic t_internal();
        cfg(4'h0, 4'h0, 3'h7, 1'b1, 1'b0);
        core(1'b1, 1'b1, 1'b0, 16'hbfff, 24'ha5_c3e1, 1'b0, 14'h0000, 0, 1'b0, 24'h00_0000);
        core(1'b1, 1'b0, 1'b0, 16'hbfff, 24'h00_0000, 1'b0, 14'h0000, 0, 1'b0, 24'ha5_c3e1);
        core(0, 1, 0, 16'hdfff, 24'h12_5a3c, 1'b0, 14'h0000, 0, 1'b0, 24'h00_0000);
        core(0, 0, 0, 16'hdfff, 24'h00_0000, 1'b0, 14'h0000, 0, 1'b0, 24'h00_5a3c);
        $display("Test internal done");
    endtask

    task automatic t_dm_ovl();
        logic [2:0] wc [3] = '{3'h0, 3'h5, 3'h2};
        logic       wm [3] = '{1'b0, 1'b0, 1'b1};
        int         w;
        for (int i = 0; i < 3; i++) begin
            w = wm[i] ? 2 * wc[i] + 1 : wc[i];
            for (int s = 1; s <= 2; s++) begin
                cfg(4'h0, 4'(s), wc[i], wm[i], 1'b0);
                core(0, 1, 0, 16'h1fff, {8'h00, 8'(i), 8'(s)}, 1, {s == 2, 13'h1fff}, w, 0, 0);
            end
            cfg(4'h0, 4'h1, wc[i], wm[i], 1'b0);
            core(0, 0, 0, 16'h1fff, 0, 1, 14'h1fff, w, 0, {8'h00, 8'(i), 8'h01});
        end
        $display("Test data overlay done");
    endtask

    task automatic t_pm_ovl();
        for (int s = 1; s <= 2; s++) begin
            cfg(4'(s), 4'h0, 3'h1, 1'b0, 1'b0);
            core(1, 1, 0, 16'h2000, 24'(24'hf0_0a00 + s), 1, {s == 2, 13'h0000}, 1, 0, 0);
            core(1, 0, 1, 16'h2000, 0, 1, {s == 2, 13'h0000}, 1, 0, 24'(24'hf0_0a00 + s));
        end
        $display("Test program overlay done");
    endtask

    task automatic t_outside();
        cfg(4'h2, 4'h1, 3'h3, 1'b0, 1'b0);
        core(0, 1, 0, 16'h2000, 24'h00_1111, 0, 14'h0000, 0, 0, 0);
        core(1, 1, 0, 16'h1fff, 24'h22_2222, 0, 14'h0000, 0, 0, 0);
        core(1, 1, 0, 16'h4000, 24'h33_3333, 0, 14'h0000, 0, 0, 0);
        cfg(4'h0, 4'h0, 3'h3, 1'b0, 1'b0);
        core(1, 1, 0, 16'h2100, 24'h44_4444, 0, 14'h0000, 0, 0, 0);
        $display("Test outside window done");
    endtask

    task automatic t_host();
        cfg(4'h2, 4'h1, 3'h0, 1'b0, 1'b1);
        core(0, 1, 0, 16'h1235, 24'h00_beef, 1, 14'h0001, 0, 0, 0);
        core(0, 0, 0, 16'h1235, 0, 1, 14'h0001, 0, 0, 24'h00_beef);
        core(1, 1, 0, 16'h2ffe, 24'h00_cafe, 1, 14'h0000, 0, 0, 0);
        core(1, 0, 1, 16'h2001, 0, 0, 14'h0000, 0, 1, 0);
        core(1, 1, 0, 16'h0100, 24'h55_5555, 0, 14'h0000, 0, 0, 0);
        $display("Test host mode done");
    endtask

    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_internal();
        t_dm_ovl();
        t_pm_ovl();
        t_outside();
        t_host();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
